// [inc/pbseq_pkg.sv]
// pbseq_pkg: constants and types for the pushbutton power sequencer
package pbseq_pkg;
  // clock rate in kHz (20 MHz)
  localparam int unsigned CLK_KHZ      = 20000;
  // timer figures as printed, in ms or us
  localparam int unsigned DB_MS        = 32;
  localparam int unsigned BLANK_MS     = 512;
  localparam int unsigned LOCK_MS      = 256;
  localparam int unsigned DEADLINE_MS  = 1024;
  localparam int unsigned KFILT_US     = 30;
  // one ms tick divider, in clock cycles
  localparam int unsigned TICK_CYC     = CLK_KHZ;
  // shutdown request filter, least time rounded up to cycles
  localparam int unsigned KFILT_CYC    = (KFILT_US * CLK_KHZ + 999) / 1000;
  // widths of counters
  localparam int unsigned TICK_W       = 15;
  localparam int unsigned MS_W         = 16;
  localparam int unsigned KF_W         = 10;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [KF_W-1:0]   KFILT_LAST = KF_W'(KFILT_CYC - 1);
  localparam logic [MS_W-1:0]   DB_CNT   = MS_W'(DB_MS);
  localparam logic [MS_W-1:0]   BLANK_CNT = MS_W'(BLANK_MS);
  localparam logic [MS_W-1:0]   LOCK_CNT = MS_W'(LOCK_MS);
  localparam logic [MS_W-1:0]   DEADLINE_CNT = MS_W'(DEADLINE_MS);
  // extension counts are whole ms, zero means none
  localparam int unsigned EXT_W        = 12;

  // sequencer states
  typedef enum logic [2:0] {
    PBSEQ_IDLE,
    PBSEQ_ON_DB,
    PBSEQ_BLANK,
    PBSEQ_REL_DB,
    PBSEQ_RUN,
    PBSEQ_OFF_DB,
    PBSEQ_DEADLINE,
    PBSEQ_LOCKOUT
  } pbseq_state_e;
endpackage : pbseq_pkg

// [design/pbseq_top.sv]
// pbseq_top: pushbutton on/off power sequencer with shutdown handshake
// Summary of operation
// - request low after blanking aborts power-up
// - filtered request low drops enable immediately, except during blanking
// - ignore button 256ms after request shutdown
// - enable polarity selectable, timing identical
// - 32ms press qualification plus independent extensions
// - enable drops within 1024ms of the shutdown interrupt
// - request low must last 30us
// - button high resets press debounce timers
// - off press asserts interrupt, starts deadline
// - no sampling during 512ms blanking
// - release debounced 32ms after acted press
`timescale 1ns/10ps
module pbseq_top
  import pbseq_pkg::*;
#(
  parameter bit          EN_ACTIVE_HIGH = 1'b1,     // enable polarity variant
  parameter int unsigned TICK_CYCLES    = TICK_CYC  // clock cycles per ms tick
) (
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  input  wire logic                         clk_en,
  input  wire logic                         pushbutton_n,
  input  wire logic                         shutdown_req_n,
  input  wire logic [pbseq_pkg::EXT_W-1:0]  on_extension,
  input  wire logic [pbseq_pkg::EXT_W-1:0]  off_extension,
  output logic                              power_en,
  output logic                              shutdown_int_n
);
  import pbseq_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [1:0]        pb_sync;   // button synchroniser
    logic [1:0]        kr_sync;   // request synchroniser
    logic [TICK_W-1:0] tick_cnt;  // ms prescaler
    logic              tick;      // ms pulse
    logic [KF_W-1:0]   kf_cnt;    // request low filter
    logic              kill;      // filtered request low
    logic [MS_W-1:0]   ms_cnt;    // interval counter
    pbseq_state_e      state;     // sequencer state
    logic              en_on;     // enable, logical sense
    logic              int_n;     // interrupt pin level
    logic              en_pin;    // enable pin level
  } pbseq_s;

  pbseq_s st_q;  // registered state
  pbseq_s st_d;  // next state

  // last prescaler count of one ms tick
  localparam logic [TICK_W-1:0] TICK_END = TICK_W'(TICK_CYCLES - 1);

  // level of enable pin for a logical state
  function automatic logic pbseq_pin(input logic on);
    return EN_ACTIVE_HIGH ? on : ~on;
  endfunction : pbseq_pin

  logic            pb_low;    // synchronised button pressed
  logic [MS_W-1:0] on_lim;    // on qualification in ms
  logic [MS_W-1:0] off_lim;   // off qualification in ms

  assign pb_low  = ~st_q.pb_sync[1];
  assign on_lim  = DB_CNT + MS_W'(on_extension);
  assign off_lim = DB_CNT + MS_W'(off_extension);

  // next-state logic
  always_comb begin
    st_d         = st_q;
    st_d.pb_sync = {st_q.pb_sync[0], pushbutton_n};
    st_d.kr_sync = {st_q.kr_sync[0], shutdown_req_n};
    // single ms tick drives the interval counter; the request filter counts clock cycles
    st_d.tick = 1'b0;
    if (st_q.tick_cnt == TICK_END) begin
      st_d.tick_cnt = '0;
      st_d.tick     = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + TICK_W'(1);
    end
    // request must stay low 30us to count
    if (st_q.kr_sync[1]) begin
      st_d.kf_cnt = '0;
      st_d.kill   = 1'b0;
    end else if (st_q.kf_cnt == KFILT_LAST) begin
      st_d.kill = 1'b1;
    end else begin
      st_d.kf_cnt = st_q.kf_cnt + KF_W'(1);
    end
    // interval counter advances on each tick
    if (st_q.tick) begin
      st_d.ms_cnt = st_q.ms_cnt + MS_W'(1);
    end
    case (st_q.state)
      PBSEQ_IDLE: begin
        st_d.ms_cnt = '0;
        if (pb_low) begin
          st_d.state = PBSEQ_ON_DB;
        end
      end
      PBSEQ_ON_DB: begin
        if (!pb_low) begin
          st_d.state  = PBSEQ_IDLE;
          st_d.ms_cnt = '0;
        end else if (st_q.ms_cnt >= on_lim) begin
          st_d.state  = PBSEQ_BLANK;
          st_d.en_on  = 1'b1;
          st_d.ms_cnt = '0;
        end
      end
      PBSEQ_BLANK: begin
        // neither input looked at until blanking ends
        if (st_q.ms_cnt >= BLANK_CNT) begin
          st_d.ms_cnt = '0;
          if (st_q.kill) begin
            st_d.en_on = 1'b0;
            st_d.state = PBSEQ_REL_DB;
          end else begin
            st_d.state = PBSEQ_REL_DB;
          end
        end
      end
      PBSEQ_REL_DB: begin
        // release must stay high 32ms
        if (st_q.kill && st_q.en_on) begin
          st_d.en_on  = 1'b0;
          st_d.state  = PBSEQ_LOCKOUT;
          st_d.ms_cnt = '0;
        end else if (pb_low) begin
          st_d.ms_cnt = '0;
        end else if (st_q.ms_cnt >= DB_CNT) begin
          st_d.ms_cnt = '0;
          st_d.state  = st_q.en_on ? PBSEQ_RUN : PBSEQ_IDLE;
        end
      end
      PBSEQ_RUN: begin
        st_d.ms_cnt = '0;
        if (st_q.kill) begin
          st_d.en_on = 1'b0;
          st_d.state = PBSEQ_LOCKOUT;
        end else if (pb_low) begin
          st_d.state = PBSEQ_OFF_DB;
        end
      end
      PBSEQ_OFF_DB: begin
        if (st_q.kill) begin
          st_d.en_on  = 1'b0;
          st_d.state  = PBSEQ_LOCKOUT;
          st_d.ms_cnt = '0;
        end else if (!pb_low) begin
          st_d.state  = PBSEQ_RUN;
          st_d.ms_cnt = '0;
        end else if (st_q.ms_cnt >= off_lim) begin
          st_d.int_n  = 1'b0;
          st_d.state  = PBSEQ_DEADLINE;
          st_d.ms_cnt = '0;
        end
      end
      PBSEQ_DEADLINE: begin
        // host normally ends this early by request
        if (st_q.kill || st_q.ms_cnt >= DEADLINE_CNT) begin
          st_d.en_on  = 1'b0;
          st_d.int_n  = 1'b1;
          st_d.ms_cnt = '0;
          st_d.state  = st_q.kill ? PBSEQ_LOCKOUT : PBSEQ_REL_DB;
        end
      end
      PBSEQ_LOCKOUT: begin
        // button ignored while rail decays
        if (st_q.ms_cnt >= LOCK_CNT) begin
          st_d.ms_cnt = '0;
          st_d.int_n  = 1'b1;
          st_d.state  = PBSEQ_REL_DB;
        end
      end
      default: begin
        st_d.state = PBSEQ_IDLE;
      end
    endcase
    st_d.en_pin = pbseq_pin(st_d.en_on);
  end

  // state register with sync reset and clock enable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q          <= '0;
      st_q.pb_sync  <= 2'h3;
      st_q.kr_sync  <= 2'h3;
      st_q.state    <= PBSEQ_IDLE;
      st_q.int_n    <= 1'b1;
      st_q.en_pin   <= ~EN_ACTIVE_HIGH;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign power_en       = st_q.en_pin;
  assign shutdown_int_n = st_q.int_n;

  // pin always matches logical enable through polarity
  property p_pol;
    @(posedge clk_sys) disable iff (srst)
      power_en == (EN_ACTIVE_HIGH ? st_q.en_on : ~st_q.en_on);
  endproperty
  a_pol: assert property (p_pol) else $error("enable polarity wrong");

  // filtered request in run drops enable next edge
  property p_kill_run;
    @(posedge clk_sys) disable iff (srst)
      (clk_en && st_q.state == PBSEQ_RUN && st_q.kill) |=> !st_q.en_on;
  endproperty
  a_kill_run: assert property (p_kill_run) else $error("kill ignored");

  // short request pulse never filters through
  property p_filt;
    @(posedge clk_sys) disable iff (srst)
      $rose(st_q.kill) |-> st_q.kf_cnt == KFILT_LAST;
  endproperty
  a_filt: assert property (p_filt) else $error("kill too early");

  // interrupt falls only out of off debounce
  property p_int;
    @(posedge clk_sys) disable iff (srst)
      $fell(shutdown_int_n) |-> st_q.state == PBSEQ_DEADLINE
        && $past(st_q.state) == PBSEQ_OFF_DB && st_q.ms_cnt == '0;
  endproperty
  a_int: assert property (p_int) else $error("bad interrupt");

  // deadline never overruns
  property p_dead;
    @(posedge clk_sys) disable iff (srst)
      st_q.state == PBSEQ_DEADLINE |-> st_q.ms_cnt <= DEADLINE_CNT;
  endproperty
  a_dead: assert property (p_dead) else $error("deadline overrun");

  // enable rises only after full on qualification
  property p_on;
    @(posedge clk_sys) disable iff (srst)
      $rose(st_q.en_on) |-> $past(st_q.ms_cnt) >= $past(on_lim)
        && $past(st_q.state) == PBSEQ_ON_DB;
  endproperty
  a_on: assert property (p_on) else $error("early turn on");

  // button release during on debounce returns idle
  property p_rel;
    @(posedge clk_sys) disable iff (srst)
      (clk_en && st_q.state == PBSEQ_ON_DB && !pb_low)
        |=> st_q.state == PBSEQ_IDLE && st_q.ms_cnt == '0;
  endproperty
  a_rel: assert property (p_rel) else $error("debounce not reset");

  // lockout leaves only after full 256ms
  property p_lock;
    @(posedge clk_sys) disable iff (srst)
      ($past(st_q.state) == PBSEQ_LOCKOUT && st_q.state != PBSEQ_LOCKOUT)
        |-> $past(st_q.ms_cnt) >= LOCK_CNT;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout short");

  // blanking holds enable regardless of inputs
  property p_blank;
    @(posedge clk_sys) disable iff (srst)
      (st_q.state == PBSEQ_BLANK && st_q.ms_cnt < BLANK_CNT) |=> st_q.en_on;
  endproperty
  a_blank: assert property (p_blank) else $error("blank broken");
endmodule : pbseq_top

// [test/pbseq_host_model.sv]
// pbseq_host_model: host that boots, then answers the shutdown interrupt
`timescale 1ns/10ps
module pbseq_host_model #(
  parameter int MS_CYC = 20000  // clock cycles per ms tick
) (
  input  wire logic clk_sys,
  input  wire logic power_on,
  input  wire logic shutdown_int_n,
  input  wire logic respond,
  input  wire logic answer,
  input  wire logic glitch,
  output logic      shutdown_req_n
);
  int boot_q;   // cycles since power came up
  int house_q;  // cycles since interrupt fell
  // boot and housekeeping time counters
  always_ff @(posedge clk_sys) begin
    boot_q  <= power_on ? boot_q + 1 : 0;
    house_q <= shutdown_int_n ? 0 : house_q + 1;
  end
  // low while unpowered or booting (100 ms), low again 5 ms after alert
  assign shutdown_req_n = power_on && respond && !glitch &&
    boot_q > 100 * MS_CYC && !(answer && house_q > 5 * MS_CYC);
endmodule : pbseq_host_model

// [test/tb.sv]
// tb: self-checking bench for the pushbutton power sequencer
`timescale 1ns/10ps
module tb;
  import pbseq_pkg::*;
  localparam int    TB_TICK = 16;  // clock cycles per ms tick in this bench
  logic             clk_sys = 0, srst = 1, pb_n = 1, clk_en = 1;
  logic             respond = 1, answer = 1, glitch = 0;
  logic [EXT_W-1:0] on_ext = '0, off_ext = '0;
  logic             en_hi, en_lo, int_n, int_lo, req_n;
  int               bad_count = 0, compares = 0, on_ms, off_ms;
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  pbseq_top #(.EN_ACTIVE_HIGH(1'b1), .TICK_CYCLES(TB_TICK)) pbseq_top_inst (
    .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
    .pushbutton_n(pb_n), .shutdown_req_n(req_n),
    .on_extension(on_ext), .off_extension(off_ext),
    .power_en(en_hi), .shutdown_int_n(int_n));
  // low-true enable variant fed the same inputs
  pbseq_top #(.EN_ACTIVE_HIGH(1'b0), .TICK_CYCLES(TB_TICK)) pbseq_top_inst_n (
    .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
    .pushbutton_n(pb_n), .shutdown_req_n(req_n),
    .on_extension(on_ext), .off_extension(off_ext),
    .power_en(en_lo), .shutdown_int_n(int_lo));
  pbseq_host_model #(.MS_CYC(TB_TICK)) pbseq_host_model_inst (
    .clk_sys(clk_sys), .power_on(en_hi), .shutdown_int_n(int_n),
    .respond(respond), .answer(answer), .glitch(glitch),
    .shutdown_req_n(req_n));
  // reference model: integer timers, button delayed through a queue
  int mdl_st = 0, mdl_cyc = 0, mdl_low = 0;
  bit mdl_on = 1'b0, mdl_int_n = 1'b1;
  bit pb_line[$] = '{1'b1, 1'b1};
  always @(posedge clk_sys) begin : mdl_step
    bit pb_s;
    bit kill;
    int low_now;
    pb_line.push_back(pb_n);
    pb_s = pb_line.pop_front();
    low_now = req_n ? 0 : mdl_low + 1;
    kill = low_now >= KFILT_CYC;
    if (srst) begin
      mdl_st    <= 0;
      mdl_cyc   <= 0;
      mdl_low   <= 0;
      mdl_on    <= 1'b0;
      mdl_int_n <= 1'b1;
    end else if (clk_en) begin
      mdl_low <= low_now;
      mdl_cyc <= mdl_cyc + 1;
      case (mdl_st)
        0: begin  // idle, waiting for a press
          mdl_cyc <= 0;
          if (!pb_s) mdl_st <= 1;
        end
        1: begin  // on qualification, any release restarts
          if (pb_s) begin
            mdl_st <= 0;
          end else if (mdl_cyc >= on_ms * TB_TICK) begin
            mdl_on  <= 1'b1;
            mdl_st  <= 2;
            mdl_cyc <= 0;
          end
        end
        2: begin  // blanking, inputs not looked at
          if (mdl_cyc >= BLANK_MS * TB_TICK) begin
            mdl_on  <= !kill;
            mdl_st  <= 3;
            mdl_cyc <= 0;
          end
        end
        3: begin  // release debounce
          if (mdl_on && kill) begin
            mdl_on  <= 1'b0;
            mdl_st  <= 7;
            mdl_cyc <= 0;
          end else if (!pb_s) begin
            mdl_cyc <= 0;
          end else if (mdl_cyc >= DB_MS * TB_TICK) begin
            mdl_st <= mdl_on ? 4 : 0;
          end
        end
        4: begin  // powered
          mdl_cyc <= 0;
          if (kill) begin
            mdl_on <= 1'b0;
            mdl_st <= 7;
          end else if (!pb_s) begin
            mdl_st <= 5;
          end
        end
        5: begin  // off qualification
          if (kill) begin
            mdl_on  <= 1'b0;
            mdl_st  <= 7;
            mdl_cyc <= 0;
          end else if (pb_s) begin
            mdl_st <= 4;
          end else if (mdl_cyc >= off_ms * TB_TICK) begin
            mdl_int_n <= 1'b0;
            mdl_st    <= 6;
            mdl_cyc   <= 0;
          end
        end
        6: begin  // turn-off deadline
          if (kill || mdl_cyc >= DEADLINE_MS * TB_TICK) begin
            mdl_on    <= 1'b0;
            mdl_int_n <= 1'b1;
            mdl_cyc   <= 0;
            mdl_st    <= kill ? 7 : 3;
          end
        end
        7: begin  // restart lockout
          if (mdl_cyc >= LOCK_MS * TB_TICK) begin
            mdl_st  <= 3;
            mdl_cyc <= 0;
          end
        end
        default: mdl_st <= 0;
      endcase
    end
  end
  // compare one value, count and report
  task automatic check(string what, logic seen, logic exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  // both variants against the expected power state
  task automatic check_on(logic exp);
    check("power_en", en_hi, exp);
    check("power_en low variant", en_lo, ~exp);
    check("interrupt variants", int_lo, int_n);
    check("power_en model", en_hi, mdl_on);
    check("shutdown_int_n model", int_n, mdl_int_n);
  endtask : check_on
  task automatic wait_ms(int n);
    repeat (n * TB_TICK) @(negedge clk_sys);
  endtask : wait_ms
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // watchdog, tests take about 4500 ticks, some 72000 cycles
  initial begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(3));
    on_ms = 32 + int'($urandom % 3);
    off_ms = 32 + int'($urandom % 3);
    on_ext = EXT_W'(on_ms - 32);
    off_ext = EXT_W'(off_ms - 32);
    repeat (5) @(negedge clk_sys);
    srst = 0;
    check_on(0);
    check("shutdown_int_n", int_n, 1);
    // two short presses must not add up
    pb_n = 0;
    wait_ms(on_ms - 2 - int'($urandom % 20));
    pb_n = 1;
    wait_ms(2);
    pb_n = 0;
    wait_ms(on_ms - 2);
    pb_n = 1;
    wait_ms(40);
    check_on(0);
    $display("test short press done");
    // turn on; host request low through blanking is ignored
    pb_n = 0;
    wait_ms(on_ms - 1);
    check_on(0);
    wait_ms(3);
    check_on(1);
    pb_n = 1;
    wait_ms(500);
    check_on(1);
    wait_ms(60);
    check_on(1);
    glitch = 1;
    repeat (400) @(negedge clk_sys);
    glitch = 0;
    wait_ms(1);
    check_on(1);
    // request held low in normal operation drops enable
    glitch = 1;
    repeat (500) @(negedge clk_sys);
    check_on(1);
    repeat (300) @(negedge clk_sys);
    check_on(0);
    glitch = 0;
    wait_ms(300);
    // power up again for the turn-off tests
    pb_n = 0;
    wait_ms(on_ms + 2);
    pb_n = 1;
    wait_ms(560);
    check_on(1);
    $display("test power on done");
    // turn-off press, host answers after housekeeping
    pb_n = 0;
    wait_ms(off_ms - 1);
    check("shutdown_int_n", int_n, 1);
    wait_ms(3);
    check("shutdown_int_n", int_n, 0);
    pb_n = 1;
    wait_ms(2);
    check_on(1);
    wait_ms(50);
    check_on(0);
    check("shutdown_int_n", int_n, 1);
    // press inside lockout is ignored
    pb_n = 0;
    wait_ms(100);
    pb_n = 1;
    wait_ms(40);
    check_on(0);
    wait_ms(200);
    $display("test host shutdown done");
    // host never boots: power-up aborts at blanking end
    respond = 0;
    pb_n = 0;
    wait_ms(on_ms + 2);
    pb_n = 1;
    check_on(1);
    wait_ms(505);
    check_on(1);
    wait_ms(10);
    check_on(0);
    wait_ms(40);
    $display("test abort done");
    // host ignores the alert: deadline forces power off
    respond = 1;
    answer = 0;
    pb_n = 0;
    wait_ms(on_ms + 2);
    pb_n = 1;
    wait_ms(560);
    pb_n = 0;
    wait_ms(off_ms + 2);
    pb_n = 1;
    wait_ms(500);
    // frozen clock enable stretches the deadline
    clk_en = 0;
    wait_ms(100);
    check_on(1);
    check("shutdown_int_n", int_n, 0);
    clk_en = 1;
    wait_ms(515);
    check_on(1);
    wait_ms(15);
    check_on(0);
    check("shutdown_int_n", int_n, 1);
    $display("test deadline done");
    give_verdict();
  end
endmodule : tb
